/* rxhb_regs.svh */
/*
 * register offsets, field positions and reset values of the receive-side
 * host buffer pointer registers.
 * assumes: included by the design file and the testbench, not by rxhb_pkg.sv; 16-bit host port.
 */
`ifndef RXHB_REGS_SVH
`define RXHB_REGS_SVH

// ****************************************************************
// register offsets (byte addresses on the host port)
// ****************************************************************
`define RXHB_OFF_ERR_LOC 12'h438
`define RXHB_OFF_ERR_WIDX 12'h43A
`define RXHB_OFF_ERR_RIDX 12'h43C
`define RXHB_OFF_PKT_LOC 12'h440
`define RXHB_OFF_PKT_RIDX 12'h442
`define RXHB_OFF_AGE_UP 12'h460
`define RXHB_OFF_STATUS 12'h400
`define RXHB_OFF_PULSE 12'h468

// ****************************************************************
// field positions and reset value
// ****************************************************************
`define RXHB_ERR_BASE_HI 8
`define RXHB_ERR_SIZE_LO 9
`define RXHB_ERR_SIZE_HI 11
`define RXHB_PKT_BASE_HI 6
`define RXHB_PKT_SIZE_LO 7
`define RXHB_PKT_SIZE_HI 8
`define RXHB_AGE_UP_HI 3
`define RXHB_ERR_PTR_HI 14
`define RXHB_STAT_PKT_OVF 0
`define RXHB_STAT_ERR_OVF 2
`define RXHB_PULSE_CELL 0
`define RXHB_RESET_VAL 16'h0000

// ****************************************************************
// buffer geometry: an error structure is 8 bytes, packet pointer in words
// ****************************************************************
`define RXHB_ERR_MIN_LOG2 9
`define RXHB_PKT_MIN_LOG2 13
`define RXHB_ERR_LOW_BITS 12
`define RXHB_PKT_LOW_BITS 14
`define RXHB_ADDR_HI 20
// above this log2 capacity a 16-bit word pointer has no spare wrap bit
`define RXHB_PTR_TOP_LOG2 5'h0F

`endif

/* rxhb_pkg.sv */
/*
 * types shared by the receive host buffer register block.
 * assumes: rxhb_regs.svh holds the numbers, this package holds types only.
 */
package rxhb_pkg;

    // host port request
    typedef struct packed {
        logic cs;
        logic wr;
        logic rd;
        logic [11:0] addr;
        logic [15:0] wdata;
    } rxhb_host_req_t;

    // whole register state of the block
    typedef struct packed {
        logic [15:0] err_loc;
        logic [14:0] err_widx;
        logic [14:0] err_ridx;
        logic [15:0] pkt_loc;
        logic [15:0] pkt_widx;
        logic [15:0] pkt_ridx;
        logic [15:0] age_up;
        logic err_ovf;
        logic pkt_ovf;
        logic cell_alarm;
        logic [15:0] rdata;
        logic err_full;
        logic pkt_full;
        logic [20:0] err_addr;
        logic [20:0] pkt_addr;
    } rxhb_state_t;

endpackage

/* rxhb_regs.sv */
/*
 * host-visible pointer registers for the error structure buffer and the
 * host-destined packet buffer, plus the upper part of the cell age limit.
 * assumes: host port is synchronous to i_clock; the receive path raises
 * one-cycle write strobes; the alarm request comes from the cell timer.
 */
`timescale 1ns/100ps
`include "rxhb_regs.svh"

module rxhb_regs
    import rxhb_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire rxhb_host_req_t i_host,
    input wire logic i_err_wr,
    input wire logic i_pkt_wr,
    input wire logic i_cell_alarm_set,
    output logic [15:0] o_rdata,
    output logic [20:0] o_err_addr,
    output logic [20:0] o_pkt_addr,
    output logic o_err_full,
    output logic o_pkt_full,
    output logic [3:0] o_cell_age_limit_upper,
    output logic o_cell_alarm
);

    rxhb_state_t s_q;
    rxhb_state_t s_d;

    // ****************************************************************
    // pointer helpers
    // ****************************************************************

    // mask for a pointer that wraps at twice capacity: bits 0..lg kept
    function automatic logic [15:0] wrap_mask(input logic [4:0] lg);
        wrap_mask = 16'((18'h1 << (lg + 5'h01)) - 18'h1);
    endfunction

    // mask of the in-buffer part of a pointer, capacity 2**lg entries
    function automatic logic [15:0] cap_mask(input logic [4:0] lg);
        cap_mask = 16'((18'h1 << lg) - 18'h1);
    endfunction

    // full when pointers differ only in the wrap bit at position lg;
    // limitation: the largest packet buffer leaves a 16-bit pointer no spare
    // bit, so there one word stays free and full is flagged one step early
    function automatic logic is_full(input logic [15:0] w, input logic [15:0] r,
                                     input logic [4:0] lg);
        if (lg > `RXHB_PTR_TOP_LOG2) begin
            is_full = (w + 16'h0001) == r;
        end else begin
            is_full = ((w ^ r) & wrap_mask(lg)) == 16'(18'h1 << lg);
        end
    endfunction

    logic [4:0] err_lg;
    logic [4:0] pkt_lg;
    logic wr_hit;

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        s_d = s_q;
        // size decode
        // entries are 8-byte structures, so 4 KB holds 512
        err_lg = 5'(`RXHB_ERR_MIN_LOG2)
               + {2'b00, s_q.err_loc[`RXHB_ERR_SIZE_HI:`RXHB_ERR_SIZE_LO]};
        // size decode; the largest size needs a fifth bit of lg
        pkt_lg = 5'(`RXHB_PKT_MIN_LOG2)
               + {3'b000, s_q.pkt_loc[`RXHB_PKT_SIZE_HI:`RXHB_PKT_SIZE_LO]};
        wr_hit = i_host.cs & i_host.wr;
        s_d.err_full = is_full({1'b0, s_q.err_widx}, {1'b0, s_q.err_ridx}, err_lg);
        s_d.pkt_full = is_full(s_q.pkt_widx, s_q.pkt_ridx, pkt_lg);
        // advance and wrap, write refused while full
        if (i_err_wr) begin
            if (s_d.err_full) begin
                s_d.err_ovf = 1'b1;
            end else begin
                s_d.err_widx = 15'(({1'b0, s_q.err_widx} + 16'h1) & wrap_mask(err_lg));
            end
        end
        if (i_pkt_wr) begin
            if (s_d.pkt_full) begin
                s_d.pkt_ovf = 1'b1;
            end else begin
                s_d.pkt_widx = (s_q.pkt_widx + 16'h1) & wrap_mask(pkt_lg);
            end
        end
        // host writes; reserved bits are stored as written, except bit 15 of the error read index
        if (wr_hit) begin
            unique case (i_host.addr)
                `RXHB_OFF_ERR_LOC: s_d.err_loc = i_host.wdata;
                `RXHB_OFF_ERR_RIDX: s_d.err_ridx = i_host.wdata[`RXHB_ERR_PTR_HI:0];
                `RXHB_OFF_PKT_LOC: s_d.pkt_loc = i_host.wdata;
                `RXHB_OFF_PKT_RIDX: s_d.pkt_ridx = i_host.wdata;
                `RXHB_OFF_AGE_UP: s_d.age_up = i_host.wdata;
                default: ;
            endcase
        end
        // alarm clear strobe; a new alarm in the same cycle wins
        if (wr_hit && i_host.addr == `RXHB_OFF_PULSE && i_host.wdata[`RXHB_PULSE_CELL]) begin
            s_d.cell_alarm = 1'b0;
        end
        if (i_cell_alarm_set) begin
            s_d.cell_alarm = 1'b1;
        end
        // read mux; unmapped addresses read zero
        s_d.rdata = `RXHB_RESET_VAL;
        if (i_host.cs && i_host.rd) begin
            unique case (i_host.addr)
                `RXHB_OFF_ERR_LOC: s_d.rdata = s_q.err_loc;
                `RXHB_OFF_ERR_WIDX: s_d.rdata = {1'b0, s_q.err_widx};
                `RXHB_OFF_ERR_RIDX: s_d.rdata = {1'b0, s_q.err_ridx};
                `RXHB_OFF_PKT_LOC: s_d.rdata = s_q.pkt_loc;
                `RXHB_OFF_PKT_RIDX: s_d.rdata = s_q.pkt_ridx;
                `RXHB_OFF_AGE_UP: s_d.rdata = s_q.age_up;
                `RXHB_OFF_STATUS: begin
                    s_d.rdata[`RXHB_STAT_ERR_OVF] = s_q.err_ovf;
                    s_d.rdata[`RXHB_STAT_PKT_OVF] = s_q.pkt_ovf;
                end
                default: s_d.rdata = `RXHB_RESET_VAL;
            endcase
        end
        // error buffer address: 8-byte slot within 4 KB-aligned base
        s_d.err_addr = {s_q.err_loc[`RXHB_ERR_BASE_HI:0], {`RXHB_ERR_LOW_BITS{1'b0}}}
                     + 21'({s_q.err_widx & 15'(cap_mask(err_lg)), 3'b000});
        // packet buffer address: word pointer, 16 KB-aligned base
        s_d.pkt_addr = {s_q.pkt_loc[`RXHB_PKT_BASE_HI:0], {`RXHB_PKT_LOW_BITS{1'b0}}}
                     + 21'({s_q.pkt_widx & cap_mask(pkt_lg), 1'b0});
    end

    // state register; overflow flags are sticky until reset
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // outputs straight from flip-flops
    assign o_rdata = s_q.rdata;
    assign o_err_addr = s_q.err_addr;
    assign o_pkt_addr = s_q.pkt_addr;
    assign o_err_full = s_q.err_full;
    assign o_pkt_full = s_q.pkt_full;
    assign o_cell_age_limit_upper = s_q.age_up[`RXHB_AGE_UP_HI:0];
    assign o_cell_alarm = s_q.cell_alarm;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    err_stop_full_a: assert property (
        i_err_wr && s_d.err_full |=> $stable(s_q.err_widx))
        else $error("error write pointer moved while full");
    pkt_stop_full_a: assert property (
        i_pkt_wr && s_d.pkt_full |=> $stable(s_q.pkt_widx))
        else $error("packet write pointer moved while full");
    err_ovf_set_a: assert property (
        i_err_wr && s_d.err_full |=> s_q.err_ovf)
        else $error("error overflow not latched");
    pkt_ovf_set_a: assert property (
        i_pkt_wr && s_d.pkt_full |=> s_q.pkt_ovf)
        else $error("packet overflow not latched");
    err_ovf_hold_a: assert property (
        s_q.err_ovf |=> s_q.err_ovf)
        else $error("error overflow flag dropped");
    err_advance_a: assert property (
        i_err_wr && !s_d.err_full |=> s_q.err_widx != $past(s_q.err_widx))
        else $error("error write pointer did not advance");
    pkt_advance_a: assert property (
        i_pkt_wr && !s_d.pkt_full |=> s_q.pkt_widx != $past(s_q.pkt_widx))
        else $error("packet write pointer did not advance");
    err_widx_ro_a: assert property (
        !i_err_wr |=> $stable(s_q.err_widx))
        else $error("error write pointer moved without a store");
    empty_not_full_a: assert property (
        s_q.err_widx == s_q.err_ridx |=> !s_q.err_full)
        else $error("empty buffer flagged full");
    pkt_empty_a: assert property (
        s_q.pkt_widx == s_q.pkt_ridx |=> !s_q.pkt_full)
        else $error("empty packet buffer flagged full");
    alarm_clear_a: assert property (
        wr_hit && i_host.addr == `RXHB_OFF_PULSE && i_host.wdata[`RXHB_PULSE_CELL]
            && !i_cell_alarm_set |=> !o_cell_alarm)
        else $error("alarm not cleared by strobe");
    alarm_set_a: assert property (
        i_cell_alarm_set |=> o_cell_alarm)
        else $error("alarm set lost");
    age_up_wr_a: assert property (
        wr_hit && i_host.addr == `RXHB_OFF_AGE_UP |=> s_q.age_up == $past(i_host.wdata))
        else $error("age limit upper not stored");
    err_base_a: assert property (
        o_err_addr[`RXHB_ADDR_HI:`RXHB_ERR_LOW_BITS] >= s_q.err_loc[`RXHB_ERR_BASE_HI:0]
            || $changed(s_q.err_loc))
        else $error("error address below base");

    cov_err_full_c: cover property (s_q.err_full);
    cov_pkt_full_c: cover property (s_q.pkt_full);
    cov_pkt_ovf_c: cover property (s_q.pkt_ovf);
    cov_alarm_c: cover property (o_cell_alarm ##1 !o_cell_alarm);
    cov_alarm_race_c: cover property (i_cell_alarm_set && wr_hit && i_host.addr == `RXHB_OFF_PULSE);

endmodule

/* rxhb_regs_tb.sv */
/*
 * self-checking testbench for the receive host buffer pointer registers.
 * assumes: rxhb_pkg.sv and rxhb_regs.svh compiled first; the block's
 * assertions live inside the design file, so no separate checker here.
 */
`timescale 1ns/100ps
`include "rxhb_regs.svh"
module rxhb_regs_tb
    import rxhb_pkg::*;
;
    logic i_clock;
    logic i_rst;
    rxhb_host_req_t i_host;
    logic i_err_wr;
    logic i_pkt_wr;
    logic i_cell_alarm_set;
    logic [15:0] o_rdata;
    logic [20:0] o_err_addr;
    logic [20:0] o_pkt_addr;
    logic o_err_full;
    logic o_pkt_full;
    logic [3:0] o_age_up;
    logic o_cell_alarm;
    int fail_count = 0;
    int samples_checked = 0;
    logic [11:0] offs [8] = '{12'h438, 12'h43A, 12'h43C, 12'h440, 12'h442, 12'h460,
        12'h400, 12'h444};
    // read pointers that make 32, 64 and 128 KB packet buffers full at 2000h
    logic [15:0] pkt_r [3] = '{16'h6000, 16'hA000, 16'h2001};

    rxhb_regs dut (.i_clock(i_clock), .i_rst(i_rst), .i_host(i_host), .i_err_wr(i_err_wr),
        .i_pkt_wr(i_pkt_wr), .i_cell_alarm_set(i_cell_alarm_set), .o_rdata(o_rdata),
        .o_err_addr(o_err_addr), .o_pkt_addr(o_pkt_addr), .o_err_full(o_err_full),
        .o_pkt_full(o_pkt_full), .o_cell_age_limit_upper(o_age_up),
        .o_cell_alarm(o_cell_alarm));

    // ****************************************************************
    // clock, checks and host port tasks
    // ****************************************************************
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    task automatic chk(input string what, input logic [20:0] seen, input logic [20:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // request held one whole cycle, released at the next falling edge
    task automatic wr(input logic [11:0] a, input logic [15:0] d);
        @(negedge i_clock) i_host = '{cs: 1'b1, wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge i_clock) i_host = '0;
    endtask

    // read data stands only in the cycle after the taking edge
    task automatic rchk(input string what, input logic [11:0] a, input logic [15:0] exp);
        @(negedge i_clock) i_host = '{cs: 1'b1, wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
        @(negedge i_clock) chk(what, {5'h00, o_rdata}, {5'h00, exp});
        i_host = '0;
    endtask

    // isolated one-cycle strobes so each counts exactly once
    task automatic strobe(input int pkt, input int n);
        for (int k = 0; k < n; k++) begin
            @(negedge i_clock) if (pkt != 0) i_pkt_wr = 1'b1; else i_err_wr = 1'b1;
            @(negedge i_clock) i_pkt_wr = 1'b0;
            i_err_wr = 1'b0;
        end
        repeat (2) @(negedge i_clock); // full flag lags the pointer by a cycle
    endtask

    task automatic results();
        $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // watchdog: the fills need about 18k cycles, allow twice that
    // ****************************************************************
    initial begin
        #400000;
        fail_count++;
        results();
    end

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        i_rst = 1'b1;
        i_host = '0;
        i_err_wr = 1'b0;
        i_pkt_wr = 1'b0;
        i_cell_alarm_set = 1'b0;
        repeat (6) @(posedge i_clock);
        @(negedge i_clock) i_rst = 1'b0;
        // every register, the status word and an unmapped place read zero
        foreach (offs[k]) rchk("reset value", offs[k], 16'h0000);
        // full-width patterns with reserved bits kept at zero
        wr(`RXHB_OFF_ERR_LOC, 16'h0BFF);
        rchk("error location", `RXHB_OFF_ERR_LOC, 16'h0BFF);
        wr(`RXHB_OFF_ERR_RIDX, 16'h7FFF);
        rchk("error read index", `RXHB_OFF_ERR_RIDX, 16'h7FFF);
        wr(`RXHB_OFF_PKT_LOC, 16'h01FF);
        rchk("packet location", `RXHB_OFF_PKT_LOC, 16'h01FF);
        wr(`RXHB_OFF_PKT_RIDX, 16'hFFFF);
        rchk("packet read index", `RXHB_OFF_PKT_RIDX, 16'hFFFF);
        wr(`RXHB_OFF_AGE_UP, 16'h000F);
        rchk("age limit upper", `RXHB_OFF_AGE_UP, 16'h000F);
        chk("age limit pins", {17'h00000, o_age_up}, 21'h00000F);
        wr(`RXHB_OFF_ERR_WIDX, 16'h1234);
        rchk("write index read only", `RXHB_OFF_ERR_WIDX, 16'h0000);
        // smallest buffers: 4 KB errors at base 3, 16 KB packets at base 2
        wr(`RXHB_OFF_ERR_LOC, 16'h0003);
        wr(`RXHB_OFF_ERR_RIDX, 16'h0000);
        wr(`RXHB_OFF_PKT_LOC, 16'h0002);
        wr(`RXHB_OFF_PKT_RIDX, 16'h0000);
        strobe(0, 1);
        chk("error slot address", o_err_addr, 21'h003008);
        strobe(0, 510);
        chk("error not yet full", {20'h00000, o_err_full}, 21'h0);
        strobe(0, 1);
        chk("error full", {20'h00000, o_err_full}, 21'h1);
        chk("error address wrapped", o_err_addr, 21'h003000);
        strobe(0, 1);
        rchk("error index held", `RXHB_OFF_ERR_WIDX, 16'h0200);
        rchk("error overflow", `RXHB_OFF_STATUS, 16'h0004);
        wr(`RXHB_OFF_ERR_RIDX, 16'h0200);
        @(negedge i_clock);
        chk("error drained", {20'h00000, o_err_full}, 21'h0);
        // size codes 1 to 5 each move the wrap bit up by one place
        for (int k = 1; k < 6; k++) begin
            wr(`RXHB_OFF_ERR_LOC, 16'h0003 | 16'(k << `RXHB_ERR_SIZE_LO));
            wr(`RXHB_OFF_ERR_RIDX, 16'h0200 ^ 16'(16'h0200 << k));
            @(negedge i_clock);
            chk("error size decode", {20'h00000, o_err_full}, 21'h000001);
        end
        strobe(1, 1);
        chk("packet word address", o_pkt_addr, 21'h008002);
        strobe(1, 8191);
        chk("packet full", {20'h00000, o_pkt_full}, 21'h1);
        strobe(1, 1);
        rchk("packet overflow", `RXHB_OFF_STATUS, 16'h0005);
        wr(`RXHB_OFF_PKT_RIDX, 16'h2000);
        @(negedge i_clock);
        chk("packet drained", {20'h00000, o_pkt_full}, 21'h0);
        // larger packet buffers; the largest keeps one word free
        for (int k = 1; k < 4; k++) begin
            wr(`RXHB_OFF_PKT_LOC, 16'h0002 | 16'(k << `RXHB_PKT_SIZE_LO));
            wr(`RXHB_OFF_PKT_RIDX, pkt_r[k - 1]);
            @(negedge i_clock);
            chk("packet size decode", {20'h00000, o_pkt_full}, 21'h000001);
        end
        chk("packet address 128 KB", o_pkt_addr, 21'h00C000);
        wr(`RXHB_OFF_PKT_RIDX, 16'h2000);
        @(negedge i_clock);
        chk("packet 128 KB empty", {20'h00000, o_pkt_full}, 21'h0);
        // alarm is sticky until the host's clear strobe
        @(negedge i_clock) i_cell_alarm_set = 1'b1;
        @(negedge i_clock) i_cell_alarm_set = 1'b0;
        repeat (3) @(negedge i_clock);
        chk("alarm raised", {20'h00000, o_cell_alarm}, 21'h1);
        wr(`RXHB_OFF_PULSE, 16'h0001);
        @(negedge i_clock);
        chk("alarm cleared", {20'h00000, o_cell_alarm}, 21'h0);
        // a new alarm in the clearing cycle must not be lost
        @(negedge i_clock) begin
            i_cell_alarm_set = 1'b1;
            i_host = '{cs: 1'b1, wr: 1'b1, rd: 1'b0, addr: `RXHB_OFF_PULSE, wdata: 16'h0001};
        end
        @(negedge i_clock) begin
            i_cell_alarm_set = 1'b0;
            i_host = '0;
        end
        chk("alarm set wins", {20'h00000, o_cell_alarm}, 21'h1);
        rchk("clear strobe reads zero", `RXHB_OFF_PULSE, 16'h0000);
        results();
    end
endmodule
